// *** common/tpf_pkg.sv ***
// Shared widths, depths and reset values for the triple port queue block
package tpf_pkg;
  // =========================================================
  // Data widths
  localparam int A_W = 36;
  localparam int BC_W = 18;
  localparam int HALF_LO = 0;
  localparam int HALF_HI = 18;
  // =========================================================
  // Queue geometry
  localparam int Q_DEPTH = 32;
  localparam int CNT_W = 6;
  localparam logic [5:0] Q_DEPTH_CNT = 6'h20;
  // =========================================================
  // Synchronised pin vector layout
  localparam int PIN_W = 63;
  localparam int P_A_DATA = 0;
  localparam int P_C_DATA = 36;
  localparam int P_A_CLK = 54;
  localparam int P_B_CLK = 55;
  localparam int P_C_CLK = 56;
  localparam int P_A_SEL_N = 57;
  localparam int P_A_GATE = 58;
  localparam int P_A_WRITE = 59;
  localparam int P_B_SEL_N = 60;
  localparam int P_C_WRITE = 61;
  localparam int P_ORDER = 62;
  // =========================================================
  // Flag reset values
  localparam logic LOW_FILL_RST = 1'b0;
  localparam logic HIGH_FILL_RST = 1'b1;
  localparam logic EMPTY_RST = 1'b0;
  localparam logic FULL_RST = 1'b0;
  localparam logic ORDER_RST = 1'b0;
endpackage

// *** src/tpf_queue.sv ***
// Flip-flop queue with valid/ready on both sides and an occupancy count
`timescale 1ns/1ps
`default_nettype none
module tpf_queue #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 32,
  parameter int CNT_W = 6
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  // Occupancy
  output logic [CNT_W-1:0] count_o
);
  localparam int IDX_W = $clog2(DEPTH);
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [IDX_W-1:0] wr_idx_reg;
  logic [IDX_W-1:0] rd_idx_reg;
  logic [CNT_W-1:0] count_reg;
  wire logic push;
  wire logic pop;

  assign in_ready_o = (count_reg != FULL_CNT);
  assign out_valid_o = (count_reg != '0);
  assign out_data_o = mem_reg[rd_idx_reg];
  assign count_o = count_reg;
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem_reg[wr_idx_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      wr_idx_reg <= '0;
      rd_idx_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_idx_reg <= (wr_idx_reg == LAST_IDX) ? '0 : wr_idx_reg + 1'b1;
      end
      if (pop) begin
        rd_idx_reg <= (rd_idx_reg == LAST_IDX) ? '0 : rd_idx_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** src/tpf_top.sv ***
// Port control, flags and mode selection of the triple port queue device
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - A almost-empty low when C-to-A count <= offset
// - B almost-empty low when A-to-B count <= offset
// - A almost-full low when A-to-B free <= offset
// - C almost-full low when C-to-A free <= offset
// - Port A is 36-bit, both directions
// - Port B is 18-bit, output only
// - Port C is 18-bit, input only
// - Select pin during reset picks byte order
// - Select pin after reset picks timing mode
// - Port A flags change on A clock edges
// - Port B flags change on B clock edges
// - Port C flags change on C clock edges
// - Port clocks may be asynchronous or coincident
// - Port A transfer needs select low
// - Port A drivers off while select high
// - Port B read needs select low
// - Port B drivers off while select high
// - Port A transfer also needs gate high
// - A full flag: full or space available
// - B ready flag marks valid output data
module tpf_top (
  // System clock and master reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Port clocks
  input wire logic a_side_clock_i,
  input wire logic b_side_clock_i,
  input wire logic c_side_clock_i,
  // Mode select
  input wire logic order_and_timing_select_i,
  // Port A
  input wire logic a_side_select_n_i,
  input wire logic a_side_transfer_gate_i,
  input wire logic a_side_write_i,
  input wire logic [35:0] a_side_data_bus_i,
  output logic [35:0] a_side_data_bus_o,
  output logic a_side_data_bus_oe_o,
  output logic a_side_full_or_in_ready_o,
  output logic a_side_empty_or_out_ready_o,
  output logic a_side_low_fill_n_o,
  output logic a_side_high_fill_n_o,
  // Port B
  input wire logic b_side_select_n_i,
  output logic [17:0] b_side_output_bus_o,
  output logic b_side_output_bus_oe_o,
  output logic b_side_empty_or_out_ready_o,
  output logic b_side_low_fill_n_o,
  // Port C
  input wire logic c_side_write_i,
  input wire logic [17:0] c_side_input_bus_i,
  output logic c_side_full_or_in_ready_o,
  output logic c_side_high_fill_n_o,
  // Flag offsets
  input wire logic [5:0] a_low_fill_offset_i,
  input wire logic [5:0] b_low_fill_offset_i,
  input wire logic [5:0] a_high_fill_offset_i,
  input wire logic [5:0] c_high_fill_offset_i
);
  // =========================================================
  // Pin synchronisers
  wire logic [tpf_pkg::PIN_W-1:0] pins_raw;
  logic [tpf_pkg::PIN_W-1:0] pins_meta_reg;
  logic [tpf_pkg::PIN_W-1:0] pins_reg;
  logic [2:0] clk_last_reg;

  assign pins_raw = {order_and_timing_select_i, c_side_write_i,
    b_side_select_n_i, a_side_write_i, a_side_transfer_gate_i,
    a_side_select_n_i, c_side_clock_i, b_side_clock_i,
    a_side_clock_i, c_side_input_bus_i, a_side_data_bus_i};

  always_ff @(posedge clk_sys_i) begin
    pins_meta_reg <= pins_raw;
    pins_reg <= pins_meta_reg;
  end

  // Tracks the pins through reset, so release shows no false edge
  always_ff @(posedge clk_sys_i) begin
    clk_last_reg <= pins_reg[tpf_pkg::P_C_CLK:tpf_pkg::P_A_CLK];
  end

  // =========================================================
  // Decoded pin levels and port clock edges
  wire logic a_edge;
  wire logic b_edge;
  wire logic c_edge;
  wire logic a_sel_n;
  wire logic a_gate;
  wire logic a_write;
  wire logic b_sel_n;
  wire logic c_write;
  wire logic sel_pin;
  wire logic [35:0] a_data;
  wire logic [17:0] c_data;

  assign a_edge = pins_reg[tpf_pkg::P_A_CLK] & ~clk_last_reg[0];
  assign b_edge = pins_reg[tpf_pkg::P_B_CLK] & ~clk_last_reg[1];
  assign c_edge = pins_reg[tpf_pkg::P_C_CLK] & ~clk_last_reg[2];
  assign a_sel_n = pins_reg[tpf_pkg::P_A_SEL_N];
  assign a_gate = pins_reg[tpf_pkg::P_A_GATE];
  assign a_write = pins_reg[tpf_pkg::P_A_WRITE];
  assign b_sel_n = pins_reg[tpf_pkg::P_B_SEL_N];
  assign c_write = pins_reg[tpf_pkg::P_C_WRITE];
  assign sel_pin = pins_reg[tpf_pkg::P_ORDER];
  assign a_data = pins_reg[tpf_pkg::P_A_DATA +: tpf_pkg::A_W];
  assign c_data = pins_reg[tpf_pkg::P_C_DATA +: tpf_pkg::BC_W];

  // =========================================================
  // Byte order and timing mode
  logic big_endian_reg;
  wire logic fall_through;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      big_endian_reg <= sel_pin;
    end
  end

  // Pin level is trusted static after reset
  assign fall_through = ~sel_pin;

  // =========================================================
  // Queues
  wire logic ab_in_valid;
  wire logic ab_in_ready;
  wire logic ab_out_valid;
  wire logic ab_out_ready;
  wire logic [35:0] ab_out_data;
  wire logic [5:0] ab_count;
  wire logic ca_in_valid;
  wire logic ca_in_ready;
  wire logic [35:0] ca_in_data;
  wire logic ca_out_valid;
  wire logic ca_out_ready;
  wire logic [35:0] ca_out_data;
  wire logic [5:0] ca_count;

  tpf_queue #(
    .WIDTH(tpf_pkg::A_W),
    .DEPTH(tpf_pkg::Q_DEPTH),
    .CNT_W(tpf_pkg::CNT_W)
  ) u_a_to_b_queue (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(ab_in_valid),
    .in_ready_o(ab_in_ready),
    .in_data_i(a_data),
    .out_valid_o(ab_out_valid),
    .out_ready_i(ab_out_ready),
    .out_data_o(ab_out_data),
    .count_o(ab_count)
  );

  tpf_queue #(
    .WIDTH(tpf_pkg::A_W),
    .DEPTH(tpf_pkg::Q_DEPTH),
    .CNT_W(tpf_pkg::CNT_W)
  ) u_c_to_a_queue (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(ca_in_valid),
    .in_ready_o(ca_in_ready),
    .in_data_i(ca_in_data),
    .out_valid_o(ca_out_valid),
    .out_ready_i(ca_out_ready),
    .out_data_o(ca_out_data),
    .count_o(ca_count)
  );

  // =========================================================
  // Port A transfers
  wire logic a_xfer;
  wire logic a_wr;
  wire logic a_rd;
  wire logic a_load;
  logic [35:0] a_out_reg;
  logic a_valid_reg;

  assign a_xfer = a_edge & ~a_sel_n & a_gate;
  assign a_wr = a_xfer & a_write;
  assign a_rd = a_xfer & ~a_write;
  assign ab_in_valid = a_wr;
  // Fall-through refills an idle output register without a read
  assign a_load = fall_through ? (a_edge & (~a_valid_reg | a_rd)) : a_rd;
  assign ca_out_ready = a_load;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      a_out_reg <= '0;
      a_valid_reg <= 1'b0;
    end else if (a_load) begin
      a_valid_reg <= ca_out_valid;
      if (ca_out_valid) begin
        a_out_reg <= ca_out_data;
      end
    end
  end

  assign a_side_data_bus_o = a_out_reg;
  assign a_side_data_bus_oe_o = ~a_sel_n & ~a_write;

  // =========================================================
  // Port B half-word output
  wire logic b_rd;
  wire logic b_load;
  wire logic b_take;
  wire logic b_first_hi;
  wire logic [17:0] b_half;
  logic [17:0] b_out_reg;
  logic b_valid_reg;
  logic b_second_reg;

  assign b_rd = b_edge & ~b_sel_n;
  assign b_load = fall_through ? (b_edge & (~b_valid_reg | ~b_sel_n))
                               : b_rd;
  assign b_take = b_load & ab_out_valid;
  // First half is the upper word in big-endian order
  assign b_first_hi = big_endian_reg ^ b_second_reg;
  assign b_half = b_first_hi ? ab_out_data[tpf_pkg::HALF_HI +: tpf_pkg::BC_W]
                             : ab_out_data[tpf_pkg::HALF_LO +: tpf_pkg::BC_W];
  assign ab_out_ready = b_take & b_second_reg;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      b_out_reg <= '0;
      b_valid_reg <= 1'b0;
      b_second_reg <= 1'b0;
    end else if (b_load) begin
      b_valid_reg <= ab_out_valid;
      if (b_take) begin
        b_out_reg <= b_half;
        b_second_reg <= ~b_second_reg;
      end
    end
  end

  assign b_side_output_bus_o = b_out_reg;
  assign b_side_output_bus_oe_o = ~b_sel_n;

  // =========================================================
  // Port C half-word input
  wire logic c_wr;
  wire logic [35:0] c_pair;
  logic [17:0] c_hold_reg;
  logic c_second_reg;

  assign c_wr = c_edge & c_write & ca_in_ready;
  assign c_pair = big_endian_reg ? {c_hold_reg, c_data}
                                 : {c_data, c_hold_reg};
  assign ca_in_data = c_pair;
  assign ca_in_valid = c_wr & c_second_reg;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      c_hold_reg <= '0;
      c_second_reg <= 1'b0;
    end else if (c_wr) begin
      c_second_reg <= ~c_second_reg;
      if (!c_second_reg) begin
        c_hold_reg <= c_data;
      end
    end
  end

  // =========================================================
  // Threshold comparisons
  wire logic [5:0] ab_free;
  wire logic [5:0] ca_free;
  wire logic a_low_next;
  wire logic b_low_next;
  wire logic a_high_next;
  wire logic c_high_next;

  assign ab_free = tpf_pkg::Q_DEPTH_CNT - ab_count;
  assign ca_free = tpf_pkg::Q_DEPTH_CNT - ca_count;
  assign a_low_next = (ca_count > a_low_fill_offset_i);
  assign b_low_next = (ab_count > b_low_fill_offset_i);
  assign a_high_next = (ab_free > a_high_fill_offset_i);
  assign c_high_next = (ca_free > c_high_fill_offset_i);

  // =========================================================
  // Port A flags
  logic a_low_reg;
  logic a_high_reg;
  logic a_full_reg;
  logic a_empty_reg;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      a_low_reg <= tpf_pkg::LOW_FILL_RST;
      a_high_reg <= tpf_pkg::HIGH_FILL_RST;
      a_full_reg <= tpf_pkg::FULL_RST;
      a_empty_reg <= tpf_pkg::EMPTY_RST;
    end else if (a_edge) begin
      a_low_reg <= a_low_next;
      a_high_reg <= a_high_next;
      a_full_reg <= ab_in_ready;
      a_empty_reg <= fall_through ? a_valid_reg : ca_out_valid;
    end
  end

  assign a_side_low_fill_n_o = a_low_reg;
  assign a_side_high_fill_n_o = a_high_reg;
  assign a_side_full_or_in_ready_o = a_full_reg;
  assign a_side_empty_or_out_ready_o = a_empty_reg;

  // =========================================================
  // Port B flags
  logic b_low_reg;
  logic b_empty_reg;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      b_low_reg <= tpf_pkg::LOW_FILL_RST;
      b_empty_reg <= tpf_pkg::EMPTY_RST;
    end else if (b_edge) begin
      b_low_reg <= b_low_next;
      b_empty_reg <= fall_through ? b_valid_reg : ab_out_valid;
    end
  end

  assign b_side_low_fill_n_o = b_low_reg;
  assign b_side_empty_or_out_ready_o = b_empty_reg;

  // =========================================================
  // Port C flags
  logic c_high_reg;
  logic c_full_reg;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      c_high_reg <= tpf_pkg::HIGH_FILL_RST;
      c_full_reg <= tpf_pkg::FULL_RST;
    end else if (c_edge) begin
      c_high_reg <= c_high_next;
      c_full_reg <= ca_in_ready;
    end
  end

  assign c_side_high_fill_n_o = c_high_reg;
  assign c_side_full_or_in_ready_o = c_full_reg;
endmodule
`default_nettype wire

// *** tb/tpf_far_clk.sv ***
// Free-running port clocks of the three far-side controllers
`timescale 1ns/1ps
`default_nettype none
module tpf_far_clk (
  // System clock
  input wire logic clk_sys_i,
  // Port clocks
  output logic a_clk_o,
  output logic b_clk_o,
  output logic c_clk_o
);
  int a_n = 0;
  int b_n = 0;
  int c_n = 0;
  initial begin
    a_clk_o = 1'b0;
    b_clk_o = 1'b0;
    c_clk_o = 1'b0;
  end
  // Half periods of 8, 10 and 12 cycles keep the three ports unrelated
  always @(posedge clk_sys_i) begin
    a_n <= (a_n == 7) ? 0 : a_n + 1;
    b_n <= (b_n == 9) ? 0 : b_n + 1;
    c_n <= (c_n == 11) ? 0 : c_n + 1;
    if (a_n == 7) a_clk_o <= ~a_clk_o;
    if (b_n == 9) b_clk_o <= ~b_clk_o;
    if (c_n == 11) c_clk_o <= ~c_clk_o;
  end
endmodule
`default_nettype wire

// *** tb/tpf_top_asserts.sv ***
// Checker for port gating and flag timing of the queue device
`timescale 1ns/1ps
`default_nettype none
module tpf_top_asserts (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Port clocks and select pin
  input wire logic a_side_clock_i,
  input wire logic b_side_clock_i,
  input wire logic c_side_clock_i,
  input wire logic order_and_timing_select_i,
  // Port controls
  input wire logic a_side_select_n_i,
  input wire logic a_side_write_i,
  input wire logic b_side_select_n_i,
  // Port A outputs
  input wire logic [35:0] a_side_data_bus_o,
  input wire logic a_side_data_bus_oe_o,
  input wire logic a_side_full_or_in_ready_o,
  input wire logic a_side_empty_or_out_ready_o,
  input wire logic a_side_low_fill_n_o,
  input wire logic a_side_high_fill_n_o,
  // Port B and C outputs
  input wire logic [17:0] b_side_output_bus_o,
  input wire logic b_side_output_bus_oe_o,
  input wire logic b_side_empty_or_out_ready_o,
  input wire logic b_side_low_fill_n_o,
  input wire logic c_side_full_or_in_ready_o,
  input wire logic c_side_high_fill_n_o
);
  // ==========================================================
  // Recent port clock rises, kept through reset on purpose
  logic [5:0] a_hist;
  logic [5:0] b_hist;
  logic [5:0] c_hist;
  always @(posedge clk_sys_i) begin
    a_hist <= {a_hist[4:0], $rose(a_side_clock_i)};
    b_hist <= {b_hist[4:0], $rose(b_side_clock_i)};
    c_hist <= {c_hist[4:0], $rose(c_side_clock_i)};
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // ==========================================================
  // Assertions
  a_drive_gate_a: assert property (a_side_data_bus_oe_o ==
    ($past(!a_side_select_n_i, 2) && $past(!a_side_write_i, 2)))
    else $error("port A drive enable wrong");
  b_drive_gate_a: assert property (
    b_side_output_bus_oe_o == $past(!b_side_select_n_i, 2))
    else $error("port B drive enable wrong");
  a_flag_time_a: assert property ($changed({a_side_full_or_in_ready_o,
    a_side_empty_or_out_ready_o, a_side_low_fill_n_o,
    a_side_high_fill_n_o}) |-> |a_hist[4:1])
    else $error("port A flag moved off an A edge");
  b_flag_time_a: assert property ($changed({b_side_empty_or_out_ready_o,
    b_side_low_fill_n_o}) |-> |b_hist[4:1])
    else $error("port B flag moved off a B edge");
  c_flag_time_a: assert property ($changed({c_side_full_or_in_ready_o,
    c_side_high_fill_n_o}) |-> |c_hist[4:1])
    else $error("port C flag moved off a C edge");
  a_data_time_a: assert property (
    $changed(a_side_data_bus_o) |-> |a_hist[4:1])
    else $error("port A data moved off an A edge");
  b_data_time_a: assert property (
    $changed(b_side_output_bus_o) |-> |b_hist[4:1])
    else $error("port B data moved off a B edge");
  a_empty_low_a: assert property (!a_side_empty_or_out_ready_o &&
    order_and_timing_select_i |-> !a_side_low_fill_n_o)
    else $error("port A empty but not almost empty");
  b_empty_low_a: assert property (!b_side_empty_or_out_ready_o &&
    order_and_timing_select_i |-> !b_side_low_fill_n_o)
    else $error("port B empty but not almost empty");
  a_full_c: cover property ($fell(a_side_full_or_in_ready_o));
  b_read_c: cover property ($rose(b_side_output_bus_oe_o));
  c_high_c: cover property ($fell(c_side_high_fill_n_o));
endmodule
bind tpf_top tpf_top_asserts u_chk (.clk_sys_i(clk_sys_i),
  .rst_n_i(rst_n_i), .a_side_clock_i(a_side_clock_i),
  .b_side_clock_i(b_side_clock_i), .c_side_clock_i(c_side_clock_i),
  .order_and_timing_select_i(order_and_timing_select_i),
  .a_side_select_n_i(a_side_select_n_i), .a_side_write_i(a_side_write_i),
  .b_side_select_n_i(b_side_select_n_i),
  .a_side_data_bus_o(a_side_data_bus_o),
  .a_side_data_bus_oe_o(a_side_data_bus_oe_o),
  .a_side_full_or_in_ready_o(a_side_full_or_in_ready_o),
  .a_side_empty_or_out_ready_o(a_side_empty_or_out_ready_o),
  .a_side_low_fill_n_o(a_side_low_fill_n_o),
  .a_side_high_fill_n_o(a_side_high_fill_n_o),
  .b_side_output_bus_o(b_side_output_bus_o),
  .b_side_output_bus_oe_o(b_side_output_bus_oe_o),
  .b_side_empty_or_out_ready_o(b_side_empty_or_out_ready_o),
  .b_side_low_fill_n_o(b_side_low_fill_n_o),
  .c_side_full_or_in_ready_o(c_side_full_or_in_ready_o),
  .c_side_high_fill_n_o(c_side_high_fill_n_o));
`default_nettype wire

// *** tb/tpf_top_tb_top.sv ***
// Self-checking bench for the triple port queue device
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("ERROR %s exp %h got %h", nm, (e), (g)); \
  end \
end
module tpf_top_tb_top;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic sel = 1'b1;
  logic a_sel_n = 1'b1, a_gate = 1'b0, a_wr = 1'b0;
  logic b_sel_n = 1'b1, c_wr = 1'b0;
  logic [35:0] a_din = 36'h0;
  logic [17:0] c_din = 18'h0;
  logic [5:0] a_lo_off = 6'h0, b_lo_off = 6'h0;
  logic [5:0] a_hi_off = 6'h0, c_hi_off = 6'h0;
  logic a_clk, b_clk, c_clk, a_oe, a_full, a_empty, a_low, a_high;
  logic b_oe, b_empty, b_low, c_full, c_high;
  logic [35:0] a_dout, w, ax;
  logic [17:0] b_dout, hc, hp, bx;
  logic [17:0] halves[$], bq[$];
  logic [35:0] aq[$];
  int error_cnt = 0, tests_run = 0, seed = 31589, cyc = 0, n;
  initial forever #10 clk_sys_i = ~clk_sys_i;
  tpf_far_clk u_far (.clk_sys_i(clk_sys_i), .a_clk_o(a_clk),
    .b_clk_o(b_clk), .c_clk_o(c_clk));
  tpf_top u_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .a_side_clock_i(a_clk), .b_side_clock_i(b_clk), .c_side_clock_i(c_clk),
    .order_and_timing_select_i(sel), .a_side_select_n_i(a_sel_n),
    .a_side_transfer_gate_i(a_gate), .a_side_write_i(a_wr),
    .a_side_data_bus_i(a_din), .a_side_data_bus_o(a_dout),
    .a_side_data_bus_oe_o(a_oe), .a_side_full_or_in_ready_o(a_full),
    .a_side_empty_or_out_ready_o(a_empty), .a_side_low_fill_n_o(a_low),
    .a_side_high_fill_n_o(a_high), .b_side_select_n_i(b_sel_n),
    .b_side_output_bus_o(b_dout), .b_side_output_bus_oe_o(b_oe),
    .b_side_empty_or_out_ready_o(b_empty), .b_side_low_fill_n_o(b_low),
    .c_side_write_i(c_wr), .c_side_input_bus_i(c_din),
    .c_side_full_or_in_ready_o(c_full), .c_side_high_fill_n_o(c_high),
    .a_low_fill_offset_i(a_lo_off), .b_low_fill_offset_i(b_lo_off),
    .a_high_fill_offset_i(a_hi_off), .c_high_fill_offset_i(c_hi_off));
  // ==========================================================
  // Port cycles: pins change after the port clock falls
  task automatic a_cyc(input logic sn, g, wr, input logic [35:0] d);
    @(negedge a_clk);
    @(posedge clk_sys_i);
    a_sel_n <= sn;
    a_gate <= g;
    a_wr <= wr;
    a_din <= d;
    @(posedge a_clk);
    repeat (4) @(posedge clk_sys_i);
  endtask
  task automatic b_cyc(input logic sn);
    @(negedge b_clk);
    @(posedge clk_sys_i);
    b_sel_n <= sn;
    @(posedge b_clk);
    repeat (4) @(posedge clk_sys_i);
  endtask
  task automatic c_cyc(input logic wr, input logic [17:0] d);
    @(negedge c_clk);
    @(posedge clk_sys_i);
    c_wr <= wr;
    c_din <= d;
    @(posedge c_clk);
    repeat (4) @(posedge clk_sys_i);
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // Output watchers take the oldest note at each enabled read
  always @(posedge a_clk) begin
    repeat (4) @(posedge clk_sys_i);
    if (!a_sel_n && a_gate && !a_wr && aq.size() > 0) begin
      ax = aq.pop_front();
      `CHK("a_data", ax, a_dout)
    end
  end
  always @(posedge b_clk) begin
    repeat (4) @(posedge clk_sys_i);
    if (!b_sel_n && bq.size() > 0) begin
      bx = bq.pop_front();
      `CHK("b_data", bx, b_dout)
    end
  end
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    @(posedge clk_sys_i);
    a_lo_off <= 6'({$random(seed)} % 33);
    b_lo_off <= 6'({$random(seed)} % 33);
    a_hi_off <= 6'({$random(seed)} % 33);
    c_hi_off <= 6'({$random(seed)} % 33);
    repeat (5) @(posedge clk_sys_i);
    `CHK("rst_flags", 4'h1, {a_full, a_empty, a_low, a_high})
    rst_n_i <= 1'b1;
    for (int k = 1; k <= 33; k++) begin
      w = 36'({$random(seed), $random(seed)});
      a_cyc(1'b0, 1'b1, 1'b1, w);
      if (k <= 32) begin
        halves.push_back(w[35:18]);
        halves.push_back(w[17:0]);
      end
      a_cyc(1'b1, 1'b1, 1'b1, w);
      n = (k > 32) ? 32 : k;
      `CHK("a_high", (32 - n) > a_hi_off, a_high)
      `CHK("a_full", n < 32, a_full)
    end
    b_cyc(1'b1);
    `CHK("b_low", 32 > b_lo_off, b_low)
    `CHK("b_empty", 1'b1, b_empty)
    for (int h = 0; h < 64; h++) begin
      if (h == 10) begin
        b_cyc(1'b1);
        `CHK("b_oe", 1'b0, b_oe)
      end
      bq.push_back(halves.pop_front());
      b_cyc(1'b0);
    end
    `CHK("b_oe", 1'b1, b_oe)
    b_cyc(1'b1);
    `CHK("b_low", 1'b0, b_low)
    `CHK("b_empty", 1'b0, b_empty)
    a_cyc(1'b1, 1'b1, 1'b1, w);
    `CHK("a_full", 1'b1, a_full)
    `CHK("a_high", 32 > a_hi_off, a_high)
    for (int k = 0; k < 16; k++) begin
      hc = 18'($random(seed));
      c_cyc(1'b1, hc);
      if (k % 2 == 1) aq.push_back({hp, hc});
      hp = hc;
    end
    c_cyc(1'b0, hc);
    `CHK("c_high", 24 > c_hi_off, c_high)
    `CHK("c_full", 1'b1, c_full)
    a_cyc(1'b1, 1'b1, 1'b0, w);
    `CHK("a_low", 8 > a_lo_off, a_low)
    a_cyc(1'b0, 1'b0, 1'b0, w);
    repeat (8) a_cyc(1'b0, 1'b1, 1'b0, w);
    `CHK("a_oe", 1'b1, a_oe)
    a_cyc(1'b1, 1'b1, 1'b0, w);
    `CHK("a_oe", 1'b0, a_oe)
    `CHK("a_low", 1'b0, a_low)
    `CHK("a_empty", 1'b0, a_empty)
    // Low pin from here on: little byte order, fall-through timing
    sel <= 1'b0;
    rst_n_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    w = 36'({$random(seed), $random(seed)});
    a_cyc(1'b0, 1'b1, 1'b1, w);
    repeat (3) b_cyc(1'b1);
    `CHK("b_ready", 1'b1, b_empty)
    `CHK("b_first", w[17:0], b_dout)
    hp = 18'($random(seed));
    hc = 18'($random(seed));
    c_cyc(1'b1, hp);
    c_cyc(1'b1, hc);
    c_cyc(1'b0, hc);
    repeat (3) a_cyc(1'b1, 1'b1, 1'b0, w);
    `CHK("a_ready", 1'b1, a_empty)
    `CHK("a_word", {hc, hp}, a_dout)
    `CHK("notes_left", 0, aq.size() + bq.size())
    end_of_test();
  end
endmodule
`default_nettype wire
